//--- pwt_timer.sv
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
module pwt_timer #(
   parameter int NB = 3
) (
   // clock and reset
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_nrst,
   // register bus
   input  wire pwt_pkg::pwt_axil_req_t i_axil,
   output pwt_pkg::pwt_axil_rsp_t      o_axil,
   // prescaled count source ticks: f1, f8, f32, subclock_div32_source
   input  wire logic [3:0]             i_count_tick,
   // a timer pins and chaining
   input  wire logic                   i_a_timer_trigger_pin,
   input  wire logic                   i_a_overflow,
   output logic                        o_a_timer_pulse_out_pin,
   output logic                        o_a_irq,
   // b timer pins and chaining
   input  wire logic [NB-1:0]          i_b_timer_event_in_pin,
   input  wire logic                   i_b_overflow,
   output logic [NB-1:0]               o_b_irq,
   output logic [NB-1:0]               o_b_underflow
);
   import pwt_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave state
   logic        aw_full;
   logic [7:0]  aw_addr;
   logic        w_full;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        bvalid;
   logic [1:0]  bresp;
   logic        rvalid;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        wr_go;

   // software registers
   // b_cnt is the live counter, read back through the data offset
   logic [A_CTRL_W-1:0] a_ctrl;
   logic                a_start;
   logic [15:0]         a_reload;
   logic [NB-1:0]       b_start;
   logic [B_MODE_W-1:0] b_mode [NB];
   logic [15:0]         b_reload [NB];
   logic [15:0]         b_cnt [NB];

   // a timer state
   // a_duty is the working copy of the reload, a_div the latched prescale
   logic        a_run;
   logic [15:0] a_cnt;
   logic [15:0] a_duty;
   logic [7:0]  a_div;
   logic [7:0]  a_pre;
   logic        a_out;

   // byte-lane merge for the 16-bit data registers
   // only lanes 0 and 1 exist, upper strobes are dropped
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   ////////////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in either order
   // the next write waits until the response slot has drained
   assign wr_go = aw_full && w_full && !bvalid;

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         aw_full <= 1'b0;
         aw_addr <= 8'h00;
         w_full  <= 1'b0;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (i_axil.awvalid && !aw_full) begin
            aw_full <= 1'b1;
            aw_addr <= i_axil.awaddr;
         end else if (wr_go) begin
            aw_full <= 1'b0;
         end
         if (i_axil.wvalid && !w_full) begin
            w_full <= 1'b1;
            w_data <= i_axil.wdata;
            w_strb <= i_axil.wstrb;
         end else if (wr_go) begin
            w_full <= 1'b0;
         end
      end
   end

   // write response and register writes
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         bvalid   <= 1'b0;
         bresp    <= RESP_OKAY;
         a_ctrl   <= CTRL_RST[A_CTRL_W-1:0];
         a_start  <= 1'b0;
         b_start  <= '0;
         a_reload <= DATA_RST;
         for (int i = 0; i < NB; i++) begin
            b_mode[i]   <= CTRL_RST[B_MODE_W-1:0];
            b_reload[i] <= DATA_RST;
         end
      end else begin
         if (bvalid && i_axil.bready) begin
            bvalid <= 1'b0;
         end
         if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= RESP_OKAY;
            if (aw_addr[7:2] == OFS_A_CTRL[7:2]) begin
               if (w_strb[0]) a_ctrl <= w_data[A_CTRL_W-1:0];
            end else if (aw_addr[7:2] == OFS_A_DATA[7:2]) begin
               a_reload <= merge16(a_reload, w_data, w_strb);
            end else if (aw_addr[7:2] == OFS_START[7:2]) begin
               if (w_strb[0]) begin
                  a_start <= w_data[START_A_BIT];
                  b_start <= w_data[START_B_LSB +: NB];
               end
            end else if (aw_addr[7:2] == OFS_STATUS[7:2]) begin
               bresp <= RESP_OKAY;                                // read-only, ignored
            end else begin
               bresp <= RESP_SLVERR;
               for (int i = 0; i < NB; i++) begin
                  if (aw_addr[7:2] == OFS_B_MODE0[7:2] + i[5:0]) begin
                     bresp <= RESP_OKAY;
                     if (w_strb[0]) b_mode[i] <= w_data[B_MODE_W-1:0];
                  end
                  if (aw_addr[7:2] == OFS_B_DATA0[7:2] + i[5:0]) begin
                     bresp       <= RESP_OKAY;
                     b_reload[i] <= merge16(b_reload[i], w_data, w_strb);
                  end
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read channel: answer one cycle after address taken
   // a new address waits while the previous answer still stands
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= RESP_OKAY;
      end else if (rvalid) begin
         if (i_axil.rready) rvalid <= 1'b0;
      end else if (i_axil.arvalid) begin
         rvalid <= 1'b1;
         rresp  <= RESP_OKAY;
         rdata  <= 32'h0000_0000;
         if (i_axil.araddr[7:2] == OFS_A_CTRL[7:2]) begin
            rdata[A_CTRL_W-1:0] <= a_ctrl;
         end else if (i_axil.araddr[7:2] == OFS_A_DATA[7:2]) begin
            rdata <= 32'h0000_0000;
         end else if (i_axil.araddr[7:2] == OFS_START[7:2]) begin
            rdata[START_B_LSB +: NB] <= b_start;
            rdata[START_A_BIT]       <= a_start;
         end else if (i_axil.araddr[7:2] == OFS_STATUS[7:2]) begin
            rdata[1:0] <= {a_run, a_out};
         end else begin
            rresp <= RESP_SLVERR;
            for (int i = 0; i < NB; i++) begin
               if (i_axil.araddr[7:2] == OFS_B_MODE0[7:2] + i[5:0]) begin
                  rresp                <= RESP_OKAY;
                  rdata[B_MODE_W-1:0]  <= b_mode[i];
               end
               if (i_axil.araddr[7:2] == OFS_B_DATA0[7:2] + i[5:0]) begin
                  rresp       <= RESP_OKAY;
                  rdata[15:0] <= b_cnt[i];
               end
            end
         end
      end
   end

   // bus outputs
   // readies drop while a word is held, stalling the next transfer
   assign o_axil.awready = !aw_full;
   assign o_axil.wready  = !w_full;
   assign o_axil.bvalid  = bvalid;
   assign o_axil.bresp   = bresp;
   assign o_axil.arready = !rvalid;
   assign o_axil.rvalid  = rvalid;
   assign o_axil.rdata   = rdata;
   assign o_axil.rresp   = rresp;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: two flops, third stage for edges
   // stage one feeds stage two only; stage three is edge history
   // all stages reset low, the idle level of the pins
   logic          trg_s1, trg_s2, trg_s3;
   logic [NB-1:0] ev_s1, ev_s2, ev_s3;

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         {trg_s1, trg_s2, trg_s3} <= 3'h0;
         ev_s1 <= '0;
         ev_s2 <= '0;
         ev_s3 <= '0;
      end else begin
         trg_s1 <= i_a_timer_trigger_pin;
         trg_s2 <= trg_s1;
         trg_s3 <= trg_s2;
         ev_s1  <= i_b_timer_event_in_pin;
         ev_s2  <= ev_s1;
         ev_s3  <= ev_s2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // a timer pwm control decode
   // unit strobe: every tick in 16-bit mode, every (m+1)th in 8-bit
   logic        a_pwm8, a_src, a_unit, a_trig, a_go, next_high;
   logic [15:0] a_top, a_n, a_elapsed;
   pwt_trig_t   a_tsel;

   assign a_pwm8    = a_ctrl[A_PWM8_BIT];
   assign a_tsel    = pwt_trig_t'(a_ctrl[A_TRIG_LSB +: 2]);
   assign a_src     = i_count_tick[a_ctrl[A_CLK_LSB +: 2]];
   assign a_top     = a_pwm8 ? TOP8 : TOP16;
   assign a_n       = a_pwm8 ? {8'h00, a_duty[15:8]} : a_duty;
   assign a_unit    = a_src && (!a_pwm8 || a_pre == 8'h00);
   assign a_elapsed = a_top - a_cnt;
   assign next_high = a_run && (a_elapsed < a_n);

   // start conditions; pin used as trigger only when selected
   // with software select the armed flag alone starts the run
   always_comb begin
      a_trig = 1'b0;
      case (a_tsel)
         PWT_TRIG_SW:  a_trig = 1'b1;
         PWT_TRIG_PIN: a_trig = a_ctrl[A_TRIG_RISE] ? (trg_s2 && !trg_s3)
                                                    : (!trg_s2 && trg_s3);
         PWT_TRIG_OVF: a_trig = i_a_overflow;
         default:      a_trig = 1'b0;
      endcase
   end
   assign a_go = a_start && !a_run && a_trig;

   // a timer counter, prescaler and reload
   // triggers are looked at only while idle, so none reloads a run
   // duty latch and prescale divisor reload together at period end
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         a_run  <= 1'b0;
         a_cnt  <= 16'h0000;
         a_duty <= DATA_RST;
         a_div  <= 8'h00;
         a_pre  <= 8'h00;
      end else if (!a_start) begin
         a_run <= 1'b0;
         if (wr_go && aw_addr[7:2] == OFS_A_DATA[7:2]) begin
            a_duty <= merge16(a_duty, w_data, w_strb);
         end
      end else if (a_go) begin
         a_run  <= 1'b1;
         a_cnt  <= a_top;
         a_duty <= a_reload;
         a_div  <= a_reload[7:0];
         a_pre  <= a_reload[7:0];
      end else if (a_run) begin
         if (a_pwm8 && a_src) begin
            a_pre <= (a_pre == 8'h00) ? a_div : a_pre - 8'h01;
         end
         if (a_unit) begin
            if (a_cnt == 16'h0000) begin
               a_cnt  <= a_top;
               a_duty <= a_reload;
               a_div  <= a_reload[7:0];
            end else begin
               a_cnt <= a_cnt - 16'h0001;
            end
         end
      end
   end

   // pulse output and falling-edge request
   // a stop drops the pulse within two cycles and raises no request
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         a_out   <= 1'b0;
         o_a_irq <= 1'b0;
      end else begin
         a_out   <= next_high;
         o_a_irq <= a_out && !next_high && a_run && a_start;
      end
   end
   assign o_a_timer_pulse_out_pin = a_out;

   ////////////////////////////////////////////////////////////////////////////
   // b timers, one per channel
   // measurement mode is not built; such a channel holds its count
   for (genvar g = 0; g < NB; g++) begin : g_b
      pwt_bmode_t bm;
      pwt_edge_t  be;
      // per-channel decode, synchronised pin edges and tick
      logic       rise, fall, pin_ev, tick, wr_data;

      assign bm      = pwt_bmode_t'(b_mode[g][B_MODE_LSB +: 2]);
      assign be      = pwt_edge_t'(b_mode[g][B_EDGE_LSB +: 2]);
      assign rise    = ev_s2[g] && !ev_s3[g];
      assign fall    = !ev_s2[g] && ev_s3[g];
      assign pin_ev  = (be == PWT_EDGE_RISE) ? rise :
                       (be == PWT_EDGE_BOTH) ? (rise || fall) : fall;
      assign wr_data = wr_go && aw_addr[7:2] == OFS_B_DATA0[7:2] + 6'(g);

      // count source per mode; measurement mode does not count here
      // the overflow source is a same-clock pulse and needs no sync
      always_comb begin
         tick = 1'b0;
         case (bm)
            PWT_BMODE_TIMER: tick = i_count_tick[b_mode[g][B_CLK_LSB +: 2]];
            PWT_BMODE_EVENT: tick = b_mode[g][B_EVSRC_BIT] ? i_b_overflow
                                                           : pin_ev;
            default:         tick = 1'b0;
         endcase
      end

      // down counter with reload on underflow
      // stopped: a data write reaches the counter; running: reload only
      always_ff @(posedge i_sys_clk or negedge i_nrst) begin
         if (!i_nrst) begin
            b_cnt[g]         <= DATA_RST;
            o_b_irq[g]       <= 1'b0;
            o_b_underflow[g] <= 1'b0;
         end else begin
            o_b_irq[g]       <= 1'b0;
            o_b_underflow[g] <= 1'b0;
            if (!b_start[g]) begin
               if (wr_data) b_cnt[g] <= merge16(b_cnt[g], w_data, w_strb);
            end else if (tick) begin
               if (b_cnt[g] == 16'h0000) begin
                  b_cnt[g]         <= b_reload[g];
                  o_b_irq[g]       <= 1'b1;
                  o_b_underflow[g] <= 1'b1;
               end else begin
                  b_cnt[g] <= b_cnt[g] - 16'h0001;
               end
            end
         end
      end
   end

endmodule : pwt_timer

//--- pwt_pkg.sv
package pwt_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_A_CTRL   = 8'h00;
   localparam logic [7:0] OFS_A_DATA   = 8'h04;
   localparam logic [7:0] OFS_START    = 8'h08;
   localparam logic [7:0] OFS_STATUS   = 8'h0C;
   localparam logic [7:0] OFS_B_MODE0  = 8'h10;
   localparam logic [7:0] OFS_B_DATA0  = 8'h20;
   localparam logic [7:0] OFS_B_STRIDE = 8'h04;
   // a control fields
   localparam int A_PWM8_BIT    = 0;
   localparam int A_CLK_LSB     = 1;
   localparam int A_TRIG_LSB    = 3;
   localparam int A_TRIG_RISE   = 5;
   localparam int A_CTRL_W      = 6;
   // b mode fields
   localparam int B_MODE_LSB    = 0;
   localparam int B_CLK_LSB     = 2;
   localparam int B_EDGE_LSB    = 4;
   localparam int B_EVSRC_BIT   = 6;
   localparam int B_MODE_W      = 7;
   // start register fields
   localparam int START_A_BIT   = 0;
   localparam int START_B_LSB   = 1;
   // reset values
   localparam logic [15:0] DATA_RST = 16'h0000;
   localparam logic [6:0]  CTRL_RST = 7'h00;
   // pwm period tops: period is top+1 units
   localparam logic [15:0] TOP16 = 16'hFFFE;
   localparam logic [15:0] TOP8  = 16'h00FE;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      PWT_TRIG_SW  = 2'b00,
      PWT_TRIG_PIN = 2'b01,
      PWT_TRIG_OVF = 2'b10
   } pwt_trig_t;

   typedef enum logic [1:0] {
      PWT_BMODE_TIMER = 2'b00,
      PWT_BMODE_EVENT = 2'b01,
      PWT_BMODE_MEAS  = 2'b10,
      PWT_BMODE_RSVD  = 2'b11
   } pwt_bmode_t;

   typedef enum logic [1:0] {
      PWT_EDGE_FALL = 2'b00,
      PWT_EDGE_RISE = 2'b01,
      PWT_EDGE_BOTH = 2'b10,
      PWT_EDGE_RSVD = 2'b11
   } pwt_edge_t;

   // axi4-lite master to slave
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } pwt_axil_req_t;

   // axi4-lite slave to master
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pwt_axil_rsp_t;
endpackage : pwt_pkg

//--- pwt_timer_sva.sv
`timescale 1ns/10ps
module pwt_timer_sva
   import pwt_pkg::*;
#(
   parameter int NB = 3
) (
   // clock and reset
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_nrst,
   // register bus
   input  wire pwt_pkg::pwt_axil_req_t i_axil,
   input  wire pwt_pkg::pwt_axil_rsp_t o_axil,
   // timer outputs
   input  wire logic                   o_a_timer_pulse_out_pin,
   input  wire logic                   o_a_irq,
   input  wire logic [NB-1:0]          o_b_irq,
   input  wire logic [NB-1:0]          o_b_underflow
);
   import pwt_pkg::*;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   ////////////////////////////////////////////////////////////////////////////
   // pwm interrupt pulse
   property p_irq_fall;
      $rose(o_a_irq) |-> $past(o_a_timer_pulse_out_pin) && !o_a_timer_pulse_out_pin;
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq without pulse fall");
   property p_irq_pulse;
      o_a_irq |=> !o_a_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
   // b interrupt and chain output agree
   property p_b_chain;
      o_b_irq == o_b_underflow;
   endproperty
   a_b_chain: assert property (p_b_chain) else $error("b irq and underflow differ");
   ////////////////////////////////////////////////////////////////////////////
   // bus answers
   property p_bresp_hold;
      o_axil.bvalid && !i_axil.bready |=> o_axil.bvalid && $stable(o_axil.bresp);
   endproperty
   a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
   property p_rdata_hold;
      o_axil.rvalid && !i_axil.rready |=> o_axil.rvalid && $stable(o_axil.rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");
   property p_ar_ready;
      o_axil.arready == !o_axil.rvalid;
   endproperty
   a_ar_ready: assert property (p_ar_ready) else $error("arready not inverse of rvalid");
   property p_wr_answer;
      i_axil.awvalid && o_axil.awready && i_axil.wvalid && o_axil.wready
         |-> ##[1:2] o_axil.bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
   property p_rd_answer;
      i_axil.arvalid && o_axil.arready |=> o_axil.rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_unmapped;
      i_axil.arvalid && o_axil.arready && i_axil.araddr >= 8'h2C
         |=> o_axil.rresp == RESP_SLVERR && o_axil.rdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   property p_a_data_rd;
      i_axil.arvalid && o_axil.arready && i_axil.araddr == OFS_A_DATA
         |=> o_axil.rdata == 32'h0000_0000;
   endproperty
   a_a_data_rd: assert property (p_a_data_rd) else $error("pwm data read not zero");
   // main scenarios
   c_pwm_rise: cover property ($rose(o_a_timer_pulse_out_pin));
   c_b_irq: cover property (o_b_irq[0]);
   c_slverr: cover property (o_axil.bvalid && o_axil.bresp == RESP_SLVERR);
endmodule : pwt_timer_sva

bind pwt_timer pwt_timer_sva #(.NB(NB)) u_sva (
   .i_sys_clk               (i_sys_clk),
   .i_nrst                  (i_nrst),
   .i_axil                  (i_axil),
   .o_axil                  (o_axil),
   .o_a_timer_pulse_out_pin (o_a_timer_pulse_out_pin),
   .o_a_irq                 (o_a_irq),
   .o_b_irq                 (o_b_irq),
   .o_b_underflow           (o_b_underflow)
);

//--- pwt_pulse_src.sv
`timescale 1ns/10ps
module pwt_pulse_src #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_nrst,
   // burst request
   input  wire logic       i_fire,
   input  wire logic [3:0] i_count,
   input  wire logic [3:0] i_half,
   // driven pin
   output logic [W-1:0]    o_pin
);
   logic [4:0] left;
   logic [3:0] ph;
   // burst of whole pulses, each half i_half+1 cycles, idle low
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         left  <= 5'h00;
         ph    <= 4'h0;
         o_pin <= '0;
      end else if (i_fire) begin
         left <= {i_count, 1'b0};
         ph   <= 4'h0;
      end else if (left != 5'h00) begin
         ph <= ph + 4'h1;
         if (ph == i_half) begin
            ph    <= 4'h0;
            o_pin <= ~o_pin;
            left  <= left - 5'h01;
         end
      end
   end
endmodule : pwt_pulse_src

//--- pwm_and_interval_event_timer_tb_top.sv
`timescale 1ns/10ps
module pwm_and_interval_event_timer_tb_top;
   import pwt_pkg::*;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
      logic [1:0]  r;
   } pwt_row_t;
   localparam pwt_row_t ROWS [6] = '{
      '{OFS_B_DATA0, 32'h0000_1234, 32'h0000_1234, RESP_OKAY},
      '{8'h24, 32'h0000_BEEF, 32'h0000_BEEF, RESP_OKAY},
      '{OFS_A_DATA, 32'h0000_5555, 32'h0000_0000, RESP_OKAY},
      '{OFS_START, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
      '{OFS_STATUS, 32'h0000_0003, 32'h0000_0000, RESP_OKAY},
      '{8'h40, 32'h0000_00FF, 32'h0000_0000, RESP_SLVERR}};
   localparam logic [7:0] EVM [4] = '{8'h11, 8'h01, 8'h21, 8'h41};
   localparam int EVN [4] = '{4, 4, 8, 4};
   localparam int DIV [4] = '{1, 8, 32, 64};
   // bench signals
   logic          clk, nrst, a_ovf, b_ovf, fa, fb, a_pin, a_out, a_irq;
   logic [3:0]    tick, a_num, a_half, b_num, b_half;
   logic [7:0]    tcnt;
   logic [2:0]    b_pin, b_irq, b_ufl;
   logic [31:0]   rv;
   logic [1:0]    rr;
   pwt_axil_req_t req;
   pwt_axil_rsp_t rsp;
   int            errors, num_checks, birq_cnt, n;
   ////////////////////////////////////////////////////////////////////////////
   pwt_timer #(.NB(3)) dut (.i_sys_clk(clk), .i_nrst(nrst), .i_axil(req), .o_axil(rsp),
      .i_count_tick(tick), .i_a_timer_trigger_pin(a_pin), .i_a_overflow(a_ovf),
      .o_a_timer_pulse_out_pin(a_out), .o_a_irq(a_irq), .i_b_timer_event_in_pin(b_pin),
      .i_b_overflow(b_ovf), .o_b_irq(b_irq), .o_b_underflow(b_ufl));
   pwt_pulse_src #(.W(1)) u_src_a (.i_sys_clk(clk), .i_nrst(nrst), .i_fire(fa),
      .i_count(a_num), .i_half(a_half), .o_pin(a_pin));
   pwt_pulse_src #(.W(3)) u_src_b (.i_sys_clk(clk), .i_nrst(nrst), .i_fire(fb),
      .i_count(b_num), .i_half(b_half), .o_pin(b_pin));
   // clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // count source ticks of 1, 8, 32 and 64 cycles
   always @(posedge clk) begin
      if (nrst !== 1'b1) begin
         tcnt     <= 8'h00;
         tick     <= 4'h0;
         birq_cnt <= 0;
      end else begin
         tcnt <= tcnt + 8'h01;
         tick <= {tcnt[5:0] == 6'h3F, tcnt[4:0] == 5'h1F, tcnt[2:0] == 3'h7, 1'b1};
         if (b_irq[0] === 1'b1) birq_cnt <= birq_cnt + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s exp %0h got %0h", nm, e, g);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw, w;
      int t;
      {aw, w, t} = '0;
      @(posedge clk);
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      {req.awvalid, req.wvalid, req.bready} <= 3'b111;
      while (!(aw && w) && t < 50) begin
         @(posedge clk);
         t++;
         if (!aw && rsp.awready === 1'b1) begin
            aw = 1'b1;
            req.awvalid <= 1'b0;
         end
         if (!w && rsp.wready === 1'b1) begin
            w = 1'b1;
            req.wvalid <= 1'b0;
         end
      end
      while (rsp.bvalid !== 1'b1 && t < 100) begin
         @(posedge clk);
         t++;
      end
      r = rsp.bresp;
      if (rsp.bvalid !== 1'b1) errors++;
      req.bready <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int t;
      t = 0;
      @(posedge clk);
      req.araddr <= a;
      {req.arvalid, req.rready} <= 2'b11;
      do begin @(posedge clk); t++; end while (rsp.arready !== 1'b1 && t < 50);
      req.arvalid <= 1'b0;
      do begin @(posedge clk); t++; end while (rsp.rvalid !== 1'b1 && t < 100);
      d = rsp.rdata;
      r = rsp.rresp;
      if (rsp.rvalid !== 1'b1) errors++;
      req.rready <= 1'b0;
   endtask : rd
   task wait_out(input logic v, input int lim, output int c);
      c = 0;
      while (a_out !== v && c < lim) begin @(posedge clk); c++; end
   endtask : wait_out
   task wait_b(input int lim, output int c);
      c = 0;
      do begin @(posedge clk); c++; end while (b_irq[0] !== 1'b1 && c < lim);
   endtask : wait_b
   // one-cycle pulse: 0 trigger burst, 1 event burst, 2 a overflow, 3 b overflow
   task fire(input int s);
      @(posedge clk);
      {b_ovf, a_ovf, fb, fa} <= 4'h1 << s;
      @(posedge clk);
      {b_ovf, a_ovf, fb, fa} <= 4'h0;
   endtask : fire
   task wrap_up;
      if (errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #(40 * 90000);
      errors++;
      wrap_up();
   end
   initial begin
      req = '0;
      {nrst, a_ovf, b_ovf, fa, fb} = '0;
      {a_num, a_half, b_num, b_half} = {4'h1, 4'h2, 4'h4, 4'h3};
      {errors, num_checks} = '0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk("reset outs", 32'h0, {rsp.bvalid, rsp.rvalid, a_out, a_irq, b_irq, b_ufl});
      chk("reset rdy", 32'h7, {rsp.awready, rsp.wready, rsp.arready});
      // register rows
      for (int i = 0; i < 6; i++) begin
         wr(ROWS[i].a, ROWS[i].d, rr);
         chk("wresp", ROWS[i].r, rr);
         rd(ROWS[i].a, rv, rr);
         chk("rdata", ROWS[i].e, rv);
         chk("rresp", ROWS[i].r, rr);
      end
      // b timer count sources, n = 1
      for (int i = 0; i < 4; i++) begin
         wr(OFS_START, 32'h0, rr);
         wr(OFS_B_MODE0, 32'(i << B_CLK_LSB), rr);
         wr(OFS_B_DATA0, 32'h1, rr);
         wr(OFS_START, 32'h2, rr);
         wait_b(300, n);
         wait_b(300, n);
         chk("b gap", 32'(2 * DIV[i]), n);
      end
      // reload-only write while counting
      wr(OFS_START, 32'h0, rr);
      wr(OFS_B_MODE0, 32'h0, rr);
      wr(OFS_B_DATA0, 32'h4, rr);
      wr(OFS_START, 32'h2, rr);
      wait_b(50, n);
      wait_b(50, n);
      chk("b gap n4", 32'd5, n);
      wr(OFS_B_DATA0, 32'h9, rr);
      wait_b(50, n);
      wait_b(50, n);
      chk("b gap n9", 32'd10, n);
      wr(OFS_START, 32'h0, rr);
      wait_b(300, n);
      chk("b stopped", 32'd300, n);
      // event counting on pin edges and overflows, n = 0
      for (int i = 0; i < 4; i++) begin
         wr(OFS_START, 32'h0, rr);
         wr(OFS_B_MODE0, 32'(EVM[i]), rr);
         wr(OFS_B_DATA0, 32'h0, rr);
         wr(OFS_START, 32'h2, rr);
         n = birq_cnt;
         if (i == 3) repeat (4) fire(3);
         else fire(1);
         repeat (60) @(posedge clk);
         chk("events", 32'(EVN[i]), 32'(birq_cnt - n));
      end
      // 8-bit pwm started by trigger pin rising edge
      wr(OFS_START, 32'h0, rr);
      wr(OFS_A_CTRL, 32'h29, rr);
      wr(OFS_A_DATA, 32'h0301, rr);
      wr(OFS_START, 32'h1, rr);
      wait_out(1'b1, 40, n);
      chk("armed idle", 32'd40, n);
      fire(0);
      wait_out(1'b1, 20, n);
      chk("pin start", 32'h1, n < 20);
      wait_out(1'b0, 600, n);
      chk("pwm8 high", 32'd6, n);
      fire(0);
      wait_out(1'b1, 600, n);
      chk("pwm8 low", 32'd504, n + 2);
      wait_out(1'b0, 600, n);
      wr(OFS_A_DATA, 32'h0501, rr);
      wait_out(1'b1, 600, n);
      wait_out(1'b0, 600, n);
      chk("pwm8 new", 32'd10, n);
      wr(OFS_START, 32'h0, rr);
      chk("stop low", 32'h0, a_out);
      // start by other timer overflow
      wr(OFS_A_CTRL, 32'h11, rr);
      wr(OFS_START, 32'h1, rr);
      fire(2);
      wait_out(1'b1, 20, n);
      chk("ovf start", 32'h1, n < 20);
      // start by falling trigger edge only
      wr(OFS_START, 32'h0, rr);
      wr(OFS_A_CTRL, 32'h09, rr);
      wr(OFS_START, 32'h1, rr);
      fire(0);
      wait_out(1'b1, 20, n);
      chk("fall start", 32'd11, n);
      // 16-bit pwm by software flag
      wr(OFS_START, 32'h0, rr);
      wr(OFS_A_CTRL, 32'h0, rr);
      wr(OFS_A_DATA, 32'h5, rr);
      wr(OFS_START, 32'h1, rr);
      wait_out(1'b1, 20, n);
      wait_out(1'b0, 70000, n);
      chk("pwm16 high", 32'd5, n);
      wait_out(1'b1, 70000, n);
      chk("pwm16 low", 32'd65530, n);
      wr(OFS_START, 32'h0, rr);
      wait_out(1'b0, 4, n);
      chk("stop fall", 32'h1, n < 4);
      wait_out(1'b1, 600, n);
      chk("stopped", 32'd600, n);
      wrap_up();
   end
endmodule : pwm_and_interval_event_timer_tb_top
